// ### alert_live_pkg.sv
// Constants and carrier types for the alert and live status bank.
// Assumes the serial interface decoder delivers one-cycle register requests.
package alert_live_pkg;

    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam logic [7:0] ALERT_SUMMARY_ADDR = 8'h3F;
    localparam logic [7:0] LIVE_STATUS_ADDR = 8'h40;
    localparam logic [7:0] CONV_CTRL_ADDR = 8'h23;
    // Result window: per-channel, diagnostic and latest-result words
    localparam logic [7:0] RESULT_FIRST_ADDR = 8'h41;
    localparam logic [7:0] RESULT_LAST_ADDR = 8'h4E;

    // ****************************************************
    // Field positions and reset values
    // ****************************************************
    localparam int RESET_FLAG_BIT = 0;
    localparam int SUPPLY_SUMMARY_BIT = 2;
    localparam int OTHER_SUMMARY_LSB = 3;
    localparam int RUN_SEL_LSB = 8;
    localparam int RUN_SEL_W = 2;
    localparam logic [1:0] RUN_ONE_SHOT = 2'h1;
    localparam logic [1:0] RUN_FREE = 2'h2;
    localparam logic [15:0] LIVE_RESET = 16'h0000;
    localparam logic RESET_FLAG_RESET = 1'b1;
    localparam logic BUSY_RESET = 1'b1;
    localparam int NUM_CH = 4;
    localparam int NUM_SUPPLY = 8;

    // ****************************************************
    // Carriers
    // ****************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic [NUM_CH-1:0] analog_port_short;
        logic [NUM_CH-1:0] analog_port_open;
        logic [NUM_CH-1:0] dig_output_short;
        logic [NUM_CH-1:0] fet_initial_phase;
        logic [NUM_CH-1:0] dig_input_short;
        logic [NUM_CH-1:0] dig_input_open;
        logic over_temp;
    } chan_cond_t;

    typedef struct packed {
        logic [NUM_SUPPLY-1:0] raw;
        logic [NUM_SUPPLY-1:0] flag;
        logic [NUM_SUPPLY-1:0] mask;
    } supply_cond_t;

    typedef struct packed {
        logic conv_done;
        logic seq_done;
        logic busy;
        logic powerup_done;
        logic ready_per_conv;
        logic [7:0] seq_last_addr;
    } adc_cond_t;

endpackage : alert_live_pkg

// ### alert_and_live_status_bank.sv
// Alert summary tail, post-reset flag, alert pin and live status register.
// Assumes all condition inputs are synchronous to clock and that register
// requests are one-cycle strobes from the serial interface decoder.
//
// What this block does
// [RULE1] Supply summary set by unmasked supply flag
// [RULE2] Post-reset flag reads one after reset
// [RULE3] Alert active after reset until cleared
// [RULE4] Write one clears flag, zero keeps
// [RULE5] Post-reset flag has no mask
// [RULE6] Live register read-only, shows present state
// [RULE7] Bits 15..12: analog short or open
// [RULE8] Bits 11..8: output short, not initial
// [RULE9] Bits 7..4: input short or open
// [RULE10] Bit 3 follows over-temperature monitor
// [RULE11] Per-sequence ready, cleared by last read
// [RULE12] Per-conversion ready, cleared by result read
// [RULE13] One-shot or free-running run selection write clears data ready
// [RULE14] Busy reads one straight after reset
// [RULE15] Bit 0 is OR of raw supply
// [RULE16] Latched bit stays while cause persists
// [RULE17] Alert active when any summary bit set
// [RULE18] Conditions arrive as synchronous inputs
module alert_and_live_status_bank #(
    parameter int NUM_CH = alert_live_pkg::NUM_CH,
    parameter int NUM_SUPPLY = alert_live_pkg::NUM_SUPPLY
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire alert_live_pkg::reg_req_t reg_req,
    output alert_live_pkg::reg_rsp_t reg_rsp,
    input wire alert_live_pkg::chan_cond_t chan_cond,
    input wire alert_live_pkg::supply_cond_t supply_cond,
    input wire alert_live_pkg::adc_cond_t adc_cond,
    input wire logic [12:0] other_summary,
    output logic alert_n
);

    // ****************************************************
    // Elaboration checks
    // ****************************************************
    // Packed carriers fix the channel and supply counts
    if (NUM_CH != alert_live_pkg::NUM_CH) begin : g_bad_ch
        $error("channel count must match the carrier");
    end
    if (NUM_SUPPLY != alert_live_pkg::NUM_SUPPLY) begin : g_bad_sup
        $error("supply count must match the carrier");
    end

    // ****************************************************
    // Decode helpers
    // ****************************************************
    // Any per-channel, diagnostic or latest-result word
    function automatic logic is_result(input logic [7:0] a);
        is_result = (a >= alert_live_pkg::RESULT_FIRST_ADDR) &&
                    (a <= alert_live_pkg::RESULT_LAST_ADDR);
    endfunction : is_result

    function automatic logic hit(input alert_live_pkg::reg_req_t r,
                                 input logic [7:0] a);
        hit = r.addr == a;
    endfunction : hit

    // ****************************************************
    // Live conditions
    // ****************************************************
    logic [15:0] live_word;
    logic supply_summary;
    logic [NUM_CH-1:0] analog_live;
    logic [NUM_CH-1:0] dout_live;
    logic [NUM_CH-1:0] din_live;

    // Per-channel OR and gating terms; inputs are already synchronous
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        assign analog_live[ch] = chan_cond.analog_port_short[ch] |
                                 chan_cond.analog_port_open[ch]; // [RULE7]
        // Detector output is ignored during the initial FET phase
        assign dout_live[ch] = chan_cond.dig_output_short[ch] &
                               ~chan_cond.fet_initial_phase[ch]; // [RULE8]
        assign din_live[ch] = chan_cond.dig_input_short[ch] |
                              chan_cond.dig_input_open[ch]; // [RULE9]
    end

    // Summary tracks present flags, so it holds while a cause persists
    assign supply_summary = |(supply_cond.flag & ~supply_cond.mask); // [RULE1] [RULE16]

    // ****************************************************
    // Converter status state
    // ****************************************************
    logic data_rdy_ff;
    logic nxt_data_rdy;
    logic powerup_ff;
    logic nxt_powerup;
    logic rdy_set;
    logic rdy_clr;
    logic run_sel_write;

    // Ready set and clear sources; a set in the clear cycle wins
    always_comb begin
        run_sel_write = 1'b0;
        if (reg_req.wr && hit(reg_req, alert_live_pkg::CONV_CTRL_ADDR)) begin
            run_sel_write = (reg_req.wdata[alert_live_pkg::RUN_SEL_LSB +:
                                alert_live_pkg::RUN_SEL_W] ==
                                alert_live_pkg::RUN_ONE_SHOT) ||
                            (reg_req.wdata[alert_live_pkg::RUN_SEL_LSB +:
                                alert_live_pkg::RUN_SEL_W] ==
                                alert_live_pkg::RUN_FREE); // [RULE13]
        end
        if (adc_cond.ready_per_conv) begin
            rdy_set = adc_cond.conv_done; // [RULE12]
            rdy_clr = reg_req.rd && is_result(reg_req.addr); // [RULE12]
        end else begin
            rdy_set = adc_cond.seq_done; // [RULE11]
            rdy_clr = reg_req.rd &&
                      hit(reg_req, adc_cond.seq_last_addr); // [RULE11]
        end
        rdy_clr = rdy_clr || run_sel_write;
        nxt_data_rdy = rdy_set || (data_rdy_ff && !rdy_clr);
        // Power-up phase holds busy until the converter reports ready
        nxt_powerup = powerup_ff && !adc_cond.powerup_done; // [RULE14]
    end

    // Converter status registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_rdy_ff <= 1'b0;
            powerup_ff <= alert_live_pkg::BUSY_RESET; // [RULE14]
        end else begin
            data_rdy_ff <= nxt_data_rdy;
            powerup_ff <= nxt_powerup;
        end
    end

    // Live word wires present conditions with the ready and power-up registers
    assign live_word = {analog_live,
                        dout_live,
                        din_live,
                        chan_cond.over_temp, // [RULE10]
                        data_rdy_ff,
                        powerup_ff | adc_cond.busy, // [RULE14]
                        |supply_cond.raw}; // [RULE15] [RULE18]

    // ****************************************************
    // Post-reset flag and alert pin
    // ****************************************************
    logic reset_flag_ff;
    logic nxt_reset_flag;
    logic alert_n_ff;
    logic nxt_alert_n;
    logic [15:0] summary_word;

    // Only a one in the flag position clears; a zero leaves it alone
    always_comb begin
        nxt_reset_flag = reset_flag_ff;
        if (reg_req.wr &&
            hit(reg_req, alert_live_pkg::ALERT_SUMMARY_ADDR) &&
            reg_req.wdata[alert_live_pkg::RESET_FLAG_BIT]) begin
            nxt_reset_flag = 1'b0; // [RULE4]
        end
    end

    // Reserved bit 1 reads zero
    assign summary_word = {other_summary,
                           supply_summary,
                           1'b0,
                           reset_flag_ff};

    // No mask term on the flag, so it always drives the pin
    always_comb begin
        nxt_alert_n = ~(|summary_word); // [RULE5] [RULE17] [RULE3]
    end

    // Flag set by any reset; pin asserted from the reset itself
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reset_flag_ff <= alert_live_pkg::RESET_FLAG_RESET; // [RULE2]
            alert_n_ff <= 1'b0; // [RULE3]
        end else begin
            reset_flag_ff <= nxt_reset_flag;
            alert_n_ff <= nxt_alert_n;
        end
    end

    assign alert_n = alert_n_ff;

    // ****************************************************
    // Register read port
    // ****************************************************
    alert_live_pkg::reg_rsp_t rsp_ff;
    alert_live_pkg::reg_rsp_t nxt_rsp;

    // Unmapped addresses answer zero; writes to live word are dropped
    always_comb begin
        nxt_rsp.valid = reg_req.rd;
        nxt_rsp.rdata = 16'h0000;
        if (reg_req.rd) begin
            if (hit(reg_req, alert_live_pkg::LIVE_STATUS_ADDR)) begin
                nxt_rsp.rdata = live_word; // [RULE6]
            end else if (hit(reg_req,
                             alert_live_pkg::ALERT_SUMMARY_ADDR)) begin
                nxt_rsp.rdata = summary_word;
            end
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    assign reg_rsp = rsp_ff;

endmodule : alert_and_live_status_bank

// ### reg_host_model.sv
// Host model that issues one-cycle register requests to the bank.
// Assumes a registered answer one cycle after the request edge.
module reg_host_model (
    input wire logic clock,
    output alert_live_pkg::reg_req_t reg_req,
    input wire alert_live_pkg::reg_rsp_t reg_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // One strobe, then idle with inverted address and data so that
    // nothing is mistaken for a held request
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge clock);
        reg_req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge clock);
        reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clock);
        q = (reg_rsp.valid === r) ? reg_rsp.rdata : 16'hxxxx;
    endtask : acc
endmodule : reg_host_model

// ### alert_live_props.sv
// Port checker for the alert and live status bank.
// Assumes it is bound onto the bank; one clock, synchronous reset.
module alert_live_props #(
    parameter int NUM_CH = 4,
    parameter int NUM_SUPPLY = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire alert_live_pkg::reg_req_t reg_req,
    input wire alert_live_pkg::reg_rsp_t reg_rsp,
    input wire alert_live_pkg::chan_cond_t chan_cond,
    input wire alert_live_pkg::supply_cond_t supply_cond,
    input wire alert_live_pkg::adc_cond_t adc_cond,
    input wire logic [12:0] other_summary,
    input wire logic alert_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic rd_live, rd_sum, cause, clr, run_wr, quiet;
    // Idle cycle: no ready set source and no write that could clear
    assign quiet = !adc_cond.conv_done && !adc_cond.seq_done && !reg_req.wr;
    // Decoded requests and alert causes
    assign rd_live = reg_req.rd && reg_req.addr == 8'h40;
    assign rd_sum = reg_req.rd && reg_req.addr == 8'h3F;
    assign cause = (|other_summary) || (|(supply_cond.flag & ~supply_cond.mask));
    assign clr = reg_req.wr && reg_req.addr == 8'h3F && reg_req.wdata[0];
    // A done pulse in the same cycle wins over the clear
    assign run_wr = reg_req.wr && reg_req.addr == 8'h23
        && (reg_req.wdata[9:8] == 2'h1 || reg_req.wdata[9:8] == 2'h2)
        && !adc_cond.conv_done && !adc_cond.seq_done;
    a_live_analog: assert property (rd_live |=> reg_rsp.rdata[15:12] ==
        $past(chan_cond.analog_port_short | chan_cond.analog_port_open))
        else $error("analog live bits wrong");
    a_live_dout: assert property (rd_live |=> reg_rsp.rdata[11:8] ==
        $past(chan_cond.dig_output_short & ~chan_cond.fet_initial_phase))
        else $error("output live bits wrong");
    a_live_din: assert property (rd_live |=> reg_rsp.rdata[7:4] ==
        $past(chan_cond.dig_input_short | chan_cond.dig_input_open))
        else $error("input live bits wrong");
    a_live_temp_sup: assert property (rd_live |=>
        reg_rsp.rdata[3] == $past(chan_cond.over_temp)
        && reg_rsp.rdata[0] == $past(|supply_cond.raw))
        else $error("temperature or supply live bit wrong");
    a_sum_supply: assert property (rd_sum |=> reg_rsp.valid &&
        reg_rsp.rdata[2] == $past(|(supply_cond.flag & ~supply_cond.mask)))
        else $error("supply summary bit wrong");
    a_alert_reset: assert property ($fell(sys_rst) |-> !alert_n)
        else $error("alert not active after reset");
    a_alert_cause: assert property (cause |=> !alert_n)
        else $error("alert not active with a cause");
    a_flag_clear: assert property (clr && !cause ##1 !cause |=> alert_n)
        else $error("alert stays after flag clear");
    a_ready_seq: assert property (adc_cond.seq_done &&
        !adc_cond.ready_per_conv ##1 quiet && !reg_req.rd ##1 rd_live
        |=> reg_rsp.rdata[2])
        else $error("data ready not set");
    a_ready_runclr: assert property (run_wr ##1 quiet ##1 quiet
        ##1 rd_live |=> !reg_rsp.rdata[2])
        else $error("data ready not cleared");
endmodule : alert_live_props
bind alert_and_live_status_bank alert_live_props #(.NUM_CH(NUM_CH),
    .NUM_SUPPLY(NUM_SUPPLY)) chk (.clock(clock), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rsp(reg_rsp), .chan_cond(chan_cond),
    .supply_cond(supply_cond), .adc_cond(adc_cond),
    .other_summary(other_summary), .alert_n(alert_n));

// ### test_alert_and_live_status_bank.sv
// Self-checking bench for the alert and live status bank.
// Assumes the host model and the bound checker are compiled alongside.
module test_alert_and_live_status_bank;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
    localparam logic [7:0] SM = alert_live_pkg::ALERT_SUMMARY_ADDR;
    localparam logic [7:0] LV = alert_live_pkg::LIVE_STATUS_ADDR;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    alert_live_pkg::reg_req_t reg_req;
    alert_live_pkg::reg_rsp_t reg_rsp;
    alert_live_pkg::chan_cond_t chan = '0;
    alert_live_pkg::supply_cond_t sup = '0;
    alert_live_pkg::adc_cond_t adc = '0;
    logic [12:0] other = '0;
    logic alert_n;
    logic [15:0] q;
    logic [23:0] s;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    alert_and_live_status_bank uut (.clock(clock), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rsp(reg_rsp), .chan_cond(chan),
        .supply_cond(sup), .adc_cond(adc), .other_summary(other),
        .alert_n(alert_n));
    reg_host_model host (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp));
    // ****************************************************
    // Expectations and bus helpers
    // ****************************************************
    function automatic logic [15:0] exp_live(input logic b);
        return {chan.analog_port_short | chan.analog_port_open,
            chan.dig_output_short & ~chan.fet_initial_phase,
            chan.dig_input_short | chan.dig_input_open, chan.over_temp,
            1'b0, b, |sup.raw};
    endfunction : exp_live
    task automatic rd(input logic [7:0] a);
        host.acc(1'b1, 1'b0, a, 16'h0000, q);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.acc(1'b0, 1'b1, a, d, q);
    endtask : wr
    // One done pulse in the chosen ready mode
    task automatic done(input logic pc);
        @(posedge clock);
        adc.ready_per_conv <= pc;
        adc.seq_last_addr <= 8'h45;
        adc.conv_done <= pc;
        adc.seq_done <= !pc;
        @(posedge clock);
        adc.conv_done <= 1'b0;
        adc.seq_done <= 1'b0;
    endtask : done
    task automatic results();
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        void'($urandom(32'h8197_71f5));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1 `CHK(alert_n, 1'b0)
        rd(SM); `CHK(q, 16'h0001)
        rd(LV); `CHK(q, 16'h0002)
        wr(SM, 16'hFFFE); rd(SM); `CHK(q[0], 1'b1)
        `CHK(alert_n, 1'b0)
        wr(SM, 16'h0001); rd(SM); `CHK(q, 16'h0000)
        `CHK(alert_n, 1'b1)
        @(posedge clock) adc.powerup_done <= 1'b1;
        @(posedge clock) adc.powerup_done <= 1'b0;
        // Random conditions; half the runs without latched causes
        for (int i = 0; i < 60; i++) begin
            s = 24'($urandom);
            if (i[0]) s[15:8] = 8'h00;
            @(posedge clock);
            chan <= 25'($urandom);
            sup <= s;
            other <= i[0] ? 13'h0000 : 13'($urandom);
            adc.busy <= 1'($urandom);
            wr(LV, 16'hFFFF);
            rd(LV); `CHK(q, exp_live(adc.busy))
            wr(SM, 16'h0004);
            rd(SM); `CHK(q, {other, |(sup.flag & ~sup.mask), 2'b00})
            `CHK(alert_n, !(|other || |(sup.flag & ~sup.mask)))
        end
        // Second reset in mid-run: flag and busy latch come back
        @(posedge clock);
        other <= '0;
        sup <= '0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1 `CHK(alert_n, 1'b0)
        rd(SM); `CHK(q, 16'h0001)
        rd(LV); `CHK(q, exp_live(1'b1))
        wr(SM, 16'h0001); rd(SM); `CHK(q, 16'h0000)
        rd(8'h10); `CHK(q, 16'h0000)
        done(1'b0); rd(LV); `CHK(q[2], 1'b1)
        rd(8'h44); rd(LV); `CHK(q[2], 1'b1)
        rd(8'h45); rd(LV); `CHK(q[2], 1'b0)
        done(1'b1); rd(LV); `CHK(q[2], 1'b1)
        rd(8'h4A); rd(LV); `CHK(q[2], 1'b0)
        // Window end points; one past the end must not clear
        done(1'b1); rd(8'h4F); rd(LV); `CHK(q[2], 1'b1)
        rd(8'h4E); rd(LV); `CHK(q[2], 1'b0)
        done(1'b1); rd(8'h41); rd(LV); `CHK(q[2], 1'b0)
        // Every run select code; only one-shot and free-running clear
        for (int r = 0; r < 4; r++) begin
            done(1'b1);
            wr(8'h23, 16'(r) << 8);
            rd(LV); `CHK(q[2], !(r == 1 || r == 2))
        end
        results();
    end
endmodule : test_alert_and_live_status_bank
